/* pkg/irq_pkg.sv */
/*
 Shared constants and types for the fixed-priority vectored interrupt
 controller: slot numbers, vector addresses, control bit positions.
 Assumes a 16-bit CPU address space with vectors at the top of memory.
*/
package irq_pkg;

    localparam int NUM_SLOTS = 16;
    localparam int SLOT_W = 4;

    // Maskable slots, index 0 is the highest maskable priority (2)
    localparam logic [3:0] SLOT_EXT_A = 4'h0;
    localparam logic [3:0] SLOT_EXT_B = 4'h1;
    localparam logic [3:0] SLOT_EXT_C_KEY = 4'h2;
    localparam logic [3:0] SLOT_CNT_A = 4'h3;
    localparam logic [3:0] SLOT_TMR_X = 4'h4;
    localparam logic [3:0] SLOT_TMR_1 = 4'h5;
    localparam logic [3:0] SLOT_TMR_2 = 4'h6;
    localparam logic [3:0] SLOT_TMR_3 = 4'h7;
    localparam logic [3:0] SLOT_TMR_4 = 4'h8;
    localparam logic [3:0] SLOT_SER1_RX = 4'h9;
    localparam logic [3:0] SLOT_SER1_TX = 4'ha;
    localparam logic [3:0] SLOT_SER2_RX = 4'hb;
    localparam logic [3:0] SLOT_SER2_TX = 4'hc;
    localparam logic [3:0] SLOT_TMR_Y_CNT_B = 4'hd;
    localparam logic [3:0] SLOT_ADC = 4'he;

    // Vector low-byte addresses; high byte is at the next odd address
    localparam logic [15:0] VEC_RESET = 16'hfffc;
    localparam logic [15:0] VEC_BREAK = 16'hffdc;
    localparam logic [15:0] VEC_TOP_MASKABLE = 16'hfffa;
    localparam logic [15:0] VEC_STEP = 16'h0002;

    // Processor status bit that holds the global disable flag
    localparam int PS_DISABLE_BIT = 2;

    // Edge-select and source-select bit positions in cfg
    localparam int EDGE_EXT_A = 0;
    localparam int EDGE_EXT_B = 1;
    localparam int EDGE_EXT_C = 2;
    localparam int EDGE_CNT_A = 3;
    localparam int EDGE_CNT_B = 4;
    localparam int SEL_KEY = 5;
    localparam int SEL_CNT_B = 6;
    localparam int CFG_W = 7;

    // Edge-selectable pins (same order as their edge bits) and 8-bit timers
    localparam int NUM_EDGE_PINS = 5;
    localparam int NUM_TIMER8 = 4;

    // Software register port
    localparam logic [2:0] ADDR_REQUEST = 3'h0;
    localparam logic [2:0] ADDR_ENABLE = 3'h1;
    localparam logic [2:0] ADDR_CONFIG = 3'h2;
    localparam logic [2:0] ADDR_STATUS = 3'h3;

    typedef enum logic [1:0] {
        KIND_NONE,
        KIND_RESET,
        KIND_MASKABLE,
        KIND_BREAK
    } irq_kind_t;

    typedef struct packed {
        logic valid;
        irq_kind_t kind;
        logic [3:0] slot;
        logic [15:0] vector;
    } vector_grant_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage : irq_pkg

/* verilog/pin_sync.sv */
/*
 Three-flop input synchroniser with agreement filter and edge outputs.
 Assumes the input comes from a pin outside the mclk domain.
*/
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;

    // Chain; a change counts once the second and third stages agree
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            meta <= '0;
            s2 <= '0;
            s3 <= '0;
        end
        else
        begin
            meta <= pin;
            s2 <= meta;
            s3 <= s2;
        end
    end

    // Filtered level and one-cycle edges
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            always_ff @(posedge mclk)
            begin
                if (rst)
                begin
                    level[i] <= 1'b0;
                    rise[i] <= 1'b0;
                    fall[i] <= 1'b0;
                end
                else
                begin
                    rise[i] <= (s2[i] == s3[i]) && s3[i] && !level[i];
                    fall[i] <= (s2[i] == s3[i]) && !s3[i] && level[i];
                    if (s2[i] == s3[i])
                        level[i] <= s3[i];
                end
            end
        end
    endgenerate

endmodule : pin_sync

/* verilog/priority_pick.sv */
/*
 Fixed-priority picker: lowest index among the qualified bits wins.
 Assumes index 0 carries the highest priority.
*/
`timescale 1ns/10ps
module priority_pick #(
    parameter int N = 16,
    parameter int W = 4
) (
    input wire logic [N-1:0] qualified,
    output logic any,
    output logic [W-1:0] index
);

    // Scan from lowest priority up so the highest one is left standing
    always_comb
    begin
        any = 1'b0;
        index = '0;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (qualified[i])
            begin
                any = 1'b1;
                index = W'(i);
            end
        end
    end

endmodule : priority_pick

/* verilog/fixed_priority_vector_irq.sv */
/*
 Fixed-priority vectored interrupt controller top: request capture,
 enable and select registers, global disable flag, arbitration and
 vector hand-off to the CPU core at instruction boundaries.
 Assumes the CPU core pulses instr_boundary once per instruction end,
 break_instruction with a break, and on-chip peripherals give
 one-cycle event pulses in the mclk domain. Slot fifteen has no
 source; its enable bit is plain storage.
*/
// How it works
// RL1: Eighteen sources, sixteen slots, fixed vector order.
// RL2: Each maskable source has request and enable bits.
// RL3: Accept when request, enable set, disable clear.
// RL4: Reset is top priority, vector FFFC/FFFD.
// RL5: Pin a, b, counter a edge-selectable requests.
// RL6: Pin c and keys share slot, selected one.
// RL7: Key request on falling AND of eight keys.
// RL8: Timer X underflow at priority six.
// RL9: Four 8-bit timers at priorities seven to ten.
// RL10: Serial one receive and transmit requests.
// RL11: Serial two receive and transmit requests.
// RL12: Timer Y or counter pin b share slot.
// RL13: Conversion complete request at priority sixteen.
// RL14: Break is non-maskable, lowest priority.
// RL15: Controller gives vector location, low byte even.
// RL16: Software reorders priority through enables and flag.
// RL17: Only highest qualified request taken; others wait.
// RL18: Acceptance clears request and sets disable flag.
// RL19: Software can clear request bits, never set.
// RL20: Disable flag is status bit two, set/clear instructions.
// RL21: Reset clears request, enable, select state.
// RL22: Acceptance only at CPU instruction boundaries.
`timescale 1ns/10ps
module fixed_priority_vector_irq #(
    parameter int NUM_KEYS = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ext_edge_pin_a,
    input wire logic ext_edge_pin_b,
    input wire logic ext_edge_pin_c,
    input wire logic counter_pin_a,
    input wire logic counter_pin_b,
    input wire logic [NUM_KEYS-1:0] key_pins,
    input wire logic timer_x_underflow,
    input wire logic [3:0] timer8_underflow,
    input wire logic [3:0] timer8_irq_selected,
    input wire logic timer_y_underflow,
    input wire logic ser1_rx_done,
    input wire logic ser1_tx_done,
    input wire logic ser1_selected,
    input wire logic ser2_rx_done,
    input wire logic ser2_tx_done,
    input wire logic ser2_selected,
    input wire logic adc_done,
    input wire logic adc_irq_selected,
    input wire logic instr_boundary,
    input wire logic break_instruction,
    input wire logic set_disable_instruction,
    input wire logic clear_disable_instruction,
    input wire irq_pkg::reg_req_t reg_req,
    output logic [15:0] reg_rdata,
    output irq_pkg::vector_grant_t grant,
    output logic disable_flag
);

    logic [irq_pkg::NUM_EDGE_PINS-1:0] pin_level;
    logic [irq_pkg::NUM_EDGE_PINS-1:0] pin_rise;
    logic [irq_pkg::NUM_EDGE_PINS-1:0] pin_fall;
    logic [NUM_KEYS-1:0] key_level;
    logic [irq_pkg::NUM_SLOTS-1:0] request;
    logic [irq_pkg::NUM_SLOTS-1:0] enable;
    logic [irq_pkg::CFG_W-1:0] cfg;
    logic [irq_pkg::NUM_SLOTS-1:0] raise;
    logic [irq_pkg::NUM_SLOTS-1:0] qualified;
    logic [irq_pkg::NUM_SLOTS-1:0] accept_clear;
    logic [irq_pkg::NUM_SLOTS-1:0] sw_clear;
    logic key_and;
    logic key_and_prev;
    logic key_fall;
    logic reset_pending;
    logic break_pending;
    logic any_maskable;
    logic [irq_pkg::SLOT_W-1:0] win_slot;
    logic take_maskable;
    logic [15:0] ps_view;
    logic [irq_pkg::NUM_EDGE_PINS-1:0] pin_edge;
    logic [irq_pkg::NUM_TIMER8-1:0] timer8_raise;
    logic write_request;
    logic write_enable;
    logic write_config;
    logic take_reset;
    logic take_break;
    irq_pkg::vector_grant_t next_grant;
    logic [15:0] next_rdata;

    // Edge pins pass the three-flop synchroniser
    pin_sync #(
        .WIDTH(irq_pkg::NUM_EDGE_PINS)
    ) u_pin_sync (
        .mclk(mclk),
        .rst(rst),
        .pin({counter_pin_b, counter_pin_a, ext_edge_pin_c,
              ext_edge_pin_b, ext_edge_pin_a}),
        .level(pin_level),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    // Key pins synchronised too; only their filtered levels are used
    pin_sync #(
        .WIDTH(NUM_KEYS)
    ) u_key_sync (
        .mclk(mclk),
        .rst(rst),
        .pin(key_pins),
        .level(key_level),
        .rise(),
        .fall()
    );

    // Falling edge of the AND of all key levels
    assign key_and = &key_level;
    assign key_fall = key_and_prev && !key_and; // see RL7

    // Reset low so idle-high keys cannot fake a falling edge
    always_ff @(posedge mclk)
    begin
        if (rst)
            key_and_prev <= 1'b0;
        else
            key_and_prev <= key_and;
    end

    // Active edge per pin; cfg bit n selects rising (1) for pin n
    genvar p;
    generate
        for (p = 0; p < irq_pkg::NUM_EDGE_PINS; p++)
        begin : g_edge
            assign pin_edge[p] = cfg[p] ? pin_rise[p] : pin_fall[p];
        end
    endgenerate

    // Each 8-bit timer raises only while its interrupt is selected
    genvar t;
    generate
        for (t = 0; t < irq_pkg::NUM_TIMER8; t++)
        begin : g_timer8
            assign timer8_raise[t] = timer8_underflow[t] &&
                timer8_irq_selected[t]; // see RL9
        end
    endgenerate

    // Event per slot; slot fifteen has no source and stays quiet
    always_comb
    begin
        raise = '0; // see RL1
        raise[irq_pkg::SLOT_EXT_A] =
            pin_edge[irq_pkg::EDGE_EXT_A]; // see RL5
        raise[irq_pkg::SLOT_EXT_B] =
            pin_edge[irq_pkg::EDGE_EXT_B]; // see RL5
        raise[irq_pkg::SLOT_EXT_C_KEY] = cfg[irq_pkg::SEL_KEY] ? key_fall :
            pin_edge[irq_pkg::EDGE_EXT_C]; // see RL6
        raise[irq_pkg::SLOT_CNT_A] =
            pin_edge[irq_pkg::EDGE_CNT_A]; // see RL5
        raise[irq_pkg::SLOT_TMR_X] = timer_x_underflow; // see RL8
        raise[irq_pkg::SLOT_TMR_4:irq_pkg::SLOT_TMR_1] = timer8_raise;
        raise[irq_pkg::SLOT_SER1_RX] = ser1_rx_done &&
            ser1_selected; // see RL10
        raise[irq_pkg::SLOT_SER1_TX] = ser1_tx_done &&
            ser1_selected; // see RL10
        raise[irq_pkg::SLOT_SER2_RX] = ser2_rx_done &&
            ser2_selected; // see RL11
        raise[irq_pkg::SLOT_SER2_TX] = ser2_tx_done &&
            ser2_selected; // see RL11
        raise[irq_pkg::SLOT_TMR_Y_CNT_B] = cfg[irq_pkg::SEL_CNT_B] ?
            pin_edge[irq_pkg::EDGE_CNT_B] : timer_y_underflow; // see RL12
        raise[irq_pkg::SLOT_ADC] = adc_done && adc_irq_selected; // see RL13
    end

    // Qualification and fixed-priority pick
    assign qualified = request & enable &
        {irq_pkg::NUM_SLOTS{!disable_flag}}; // see RL3

    priority_pick #(
        .N(irq_pkg::NUM_SLOTS),
        .W(irq_pkg::SLOT_W)
    ) u_pick (
        .qualified(qualified),
        .any(any_maskable),
        .index(win_slot)
    );

    // Maskable acceptance only at a boundary with no reset pending
    assign take_maskable = instr_boundary && !reset_pending &&
        any_maskable; // see RL22

    // Reset and break decisions of this boundary
    assign take_reset = instr_boundary && reset_pending; // see RL4
    assign take_break = instr_boundary && !reset_pending &&
        !any_maskable && break_pending; // see RL14

    always_comb
    begin
        accept_clear = '0;
        if (take_maskable)
            accept_clear[win_slot] = 1'b1; // see RL17
    end

    // Write decodes, one strobe each for request, enable and config
    assign write_request = reg_req.wr &&
        reg_req.addr == irq_pkg::ADDR_REQUEST;
    assign write_enable = reg_req.wr &&
        reg_req.addr == irq_pkg::ADDR_ENABLE;
    assign write_config = reg_req.wr &&
        reg_req.addr == irq_pkg::ADDR_CONFIG;

    // Software write of a 1 clears that request bit
    assign sw_clear = write_request ? reg_req.wdata : '0;

    // Request bits: a new event wins over any clear
    always_ff @(posedge mclk)
    begin
        if (rst)
            request <= '0; // see RL21
        else
            request <= (request & ~accept_clear & ~sw_clear) | raise; // see RL19
    end

    // Enable register, everything masked after reset
    always_ff @(posedge mclk)
    begin
        if (rst)
            enable <= '0; // see RL21
        else if (write_enable)
            enable <= reg_req.wdata; // see RL2
    end

    // Edge and source selection, back to falling edges after reset
    always_ff @(posedge mclk)
    begin
        if (rst)
            cfg <= '0; // see RL21
        else if (write_config)
            cfg <= reg_req.wdata[irq_pkg::CFG_W-1:0];
    end

    // Global disable flag: set by reset, instruction or acceptance
    always_ff @(posedge mclk)
    begin
        if (rst)
            disable_flag <= 1'b1;
        else if (set_disable_instruction)
            disable_flag <= 1'b1; // see RL20
        else if (take_reset || take_maskable || take_break)
            disable_flag <= 1'b1; // see RL18
        else if (clear_disable_instruction)
            disable_flag <= 1'b0; // see RL20
    end

    // Reset vector waits for the first boundary after reset
    always_ff @(posedge mclk)
    begin
        if (rst)
            reset_pending <= 1'b1; // see RL4
        else if (instr_boundary)
            reset_pending <= 1'b0;
    end

    // Break is latched until a boundary with nothing above it
    always_ff @(posedge mclk)
    begin
        if (rst)
            break_pending <= 1'b0;
        else if (break_instruction)
            break_pending <= 1'b1; // see RL14
        else if (take_break)
            break_pending <= 1'b0;
    end

    // Vector of this boundary's winner: reset, maskable, then break
    always_comb
    begin
        next_grant = '0;
        if (take_reset)
        begin
            next_grant.valid = 1'b1;
            next_grant.kind = irq_pkg::KIND_RESET;
            next_grant.vector = irq_pkg::VEC_RESET; // see RL4
        end
        else if (take_maskable)
        begin
            next_grant.valid = 1'b1;
            next_grant.kind = irq_pkg::KIND_MASKABLE;
            next_grant.slot = win_slot;
            next_grant.vector = irq_pkg::VEC_TOP_MASKABLE -
                16'(win_slot) * irq_pkg::VEC_STEP; // see RL15
        end
        else if (take_break)
        begin
            next_grant.valid = 1'b1;
            next_grant.kind = irq_pkg::KIND_BREAK;
            next_grant.vector = irq_pkg::VEC_BREAK; // see RL14
        end
    end

    // Vector hand-off, one-cycle grant pulse
    always_ff @(posedge mclk)
    begin
        if (rst)
            grant <= '0;
        else
            grant <= next_grant;
    end

    // Status view with the disable flag at its processor status bit
    always_comb
    begin
        ps_view = '0;
        ps_view[irq_pkg::PS_DISABLE_BIT] = disable_flag; // see RL20
    end

    // Read mux; unmapped places and idle cycles read as zero
    always_comb
    begin
        next_rdata = '0;
        if (reg_req.rd)
        begin
            case (reg_req.addr)
                irq_pkg::ADDR_REQUEST: next_rdata = request;
                irq_pkg::ADDR_ENABLE: next_rdata = enable;
                irq_pkg::ADDR_CONFIG: next_rdata = 16'(cfg);
                irq_pkg::ADDR_STATUS: next_rdata = ps_view; // see RL20
                default: next_rdata = '0;
            endcase
        end
    end

    // Read port, data one cycle after the strobe
    always_ff @(posedge mclk)
    begin
        if (rst)
            reg_rdata <= '0;
        else
            reg_rdata <= next_rdata;
    end

endmodule : fixed_priority_vector_irq

/* tb/irq_checker.sv */
/*
 Port checker for the interrupt controller: vectors, flag, reads.
 Assumes it is bound to the controller top, one clock domain.
*/
`timescale 1ns/10ps
module irq_checker (
    input wire logic mclk,
    input wire logic rst,
    input wire logic instr_boundary,
    input wire logic set_disable_instruction,
    input wire logic clear_disable_instruction,
    input wire irq_pkg::reg_req_t reg_req,
    input wire logic [15:0] reg_rdata,
    input wire irq_pkg::vector_grant_t grant,
    input wire logic disable_flag
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    // Steps of an acceptance
    sequence s_grant_mask;
        grant.valid && grant.kind == irq_pkg::KIND_MASKABLE;
    endsequence
    sequence s_masked_boundary;
        disable_flag && instr_boundary ##1 grant.valid;
    endsequence
    property p_at_boundary;
        grant.valid |-> $past(instr_boundary);
    endproperty
    a_at_boundary: assert property (p_at_boundary)
        else $error("grant without a boundary");
    property p_masked;
        s_masked_boundary |-> grant.kind != irq_pkg::KIND_MASKABLE;
    endproperty
    a_masked: assert property (p_masked)
        else $error("maskable grant while disabled");
    property p_flag_on_accept;
        s_grant_mask |-> disable_flag;
    endproperty
    a_flag_on_accept: assert property (p_flag_on_accept)
        else $error("flag not set on acceptance");
    property p_mask_vector;
        s_grant_mask |-> grant.slot <= 4'he &&
            grant.vector == 16'hfffa - {11'h000, grant.slot, 1'b0};
    endproperty
    a_mask_vector: assert property (p_mask_vector)
        else $error("maskable vector wrong");
    property p_reset_vec;
        grant.valid && grant.kind == irq_pkg::KIND_RESET
            |-> grant.vector == 16'hfffc;
    endproperty
    a_reset_vec: assert property (p_reset_vec)
        else $error("reset vector wrong");
    property p_break_vec;
        grant.valid && grant.kind == irq_pkg::KIND_BREAK
            |-> grant.vector == 16'hffdc;
    endproperty
    a_break_vec: assert property (p_break_vec)
        else $error("break vector wrong");
    property p_reset_state;
        $fell(rst) |-> disable_flag && !grant.valid &&
            reg_rdata == 16'h0000;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("state after reset wrong");
    property p_status_read;
        reg_req.rd && reg_req.addr == irq_pkg::ADDR_STATUS
            |=> reg_rdata[2] == $past(disable_flag);
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read wrong");
    property p_set_flag;
        set_disable_instruction && !clear_disable_instruction
            |=> disable_flag;
    endproperty
    a_set_flag: assert property (p_set_flag)
        else $error("set instruction ignored");
    property p_clear_flag;
        clear_disable_instruction && !set_disable_instruction &&
            !instr_boundary |=> !disable_flag;
    endproperty
    a_clear_flag: assert property (p_clear_flag)
        else $error("clear instruction ignored");
endmodule : irq_checker
bind fixed_priority_vector_irq irq_checker u_chk (
    .mclk(mclk), .rst(rst), .instr_boundary(instr_boundary),
    .set_disable_instruction(set_disable_instruction),
    .clear_disable_instruction(clear_disable_instruction),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .grant(grant),
    .disable_flag(disable_flag)
);

/* tb/cpu_core_model.sv */
/*
 Core model: ends one instruction per step and keeps the grant.
 Assumes step is a one-cycle pulse from the bench.
*/
`timescale 1ns/10ps
module cpu_core_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic step,
    input wire irq_pkg::vector_grant_t grant,
    output logic instr_boundary,
    output irq_pkg::vector_grant_t taken
);
    // One instruction end per step
    always_ff @(posedge mclk)
    begin
        if (rst)
            instr_boundary <= 1'b0;
        else
            instr_boundary <= step;
    end
    // Grant that followed the last boundary, empty if none
    always_ff @(posedge mclk)
    begin
        if (rst || instr_boundary)
            taken <= '0;
        else if (grant.valid)
            taken <= grant;
    end
endmodule : cpu_core_model

/* tb/test_fixed_priority_vector_irq.sv */
/*
 Bench: register, event, pin and boundary sequences with checks.
 Assumes the core model makes boundaries and holds grants.
*/
`timescale 1ns/10ps
module test_fixed_priority_vector_irq;
    logic mclk;
    logic rst;
    logic [4:0] pin;
    logic [7:0] keys;
    logic [14:0] pv;
    logic [6:0] sel;
    irq_pkg::reg_req_t req;
    logic [15:0] rdata;
    irq_pkg::vector_grant_t grant;
    irq_pkg::vector_grant_t taken;
    logic boundary;
    logic disable_flag;
    int errors = 0;
    int compares = 0;
    int cycles = 0;

    fixed_priority_vector_irq #(.NUM_KEYS(8)) DUT (
        .mclk(mclk), .rst(rst), .ext_edge_pin_a(pin[0]),
        .ext_edge_pin_b(pin[1]), .ext_edge_pin_c(pin[2]),
        .counter_pin_a(pin[3]), .counter_pin_b(pin[4]), .key_pins(keys),
        .timer_x_underflow(pv[0]), .timer8_underflow(pv[4:1]),
        .timer8_irq_selected(sel[3:0]), .timer_y_underflow(pv[9]),
        .ser1_rx_done(pv[5]), .ser1_tx_done(pv[6]), .ser1_selected(sel[4]),
        .ser2_rx_done(pv[7]), .ser2_tx_done(pv[8]), .ser2_selected(sel[5]),
        .adc_done(pv[10]), .adc_irq_selected(sel[6]),
        .instr_boundary(boundary), .break_instruction(pv[11]),
        .set_disable_instruction(pv[12]),
        .clear_disable_instruction(pv[13]), .reg_req(req),
        .reg_rdata(rdata), .grant(grant), .disable_flag(disable_flag)
    );
    cpu_core_model core (
        .mclk(mclk), .rst(rst), .step(pv[14]), .grant(grant),
        .instr_boundary(boundary), .taken(taken)
    );

    // Clock
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic report_and_stop;
        if (errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop

    // Hang guard
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h expected %h",
                $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge mclk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        req <= '0;
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [15:0] exp);
        @(posedge mclk);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        req <= '0;
        #1;
        chk(rdata, exp);
    endtask : rd

    // One-cycle pulse on events, core controls and step
    task automatic pulse(input logic [14:0] m);
        @(posedge mclk);
        pv <= m;
        @(posedge mclk);
        pv <= '0;
    endtask : pulse

    task automatic accept(input irq_pkg::irq_kind_t k,
        input logic [15:0] v);
        pulse(15'h4000);
        tick(3);
        chk({14'h0000, taken.kind}, {14'h0000, k});
        chk(taken.vector, v);
    endtask : accept

    task automatic set_pins(input logic [4:0] p, input logic [7:0] k);
        @(posedge mclk);
        pin <= p;
        keys <= k;
        tick(8);
    endtask : set_pins

    // Main sequence
    initial
    begin
        rst = 1'b1;
        pin = '0;
        keys = 8'hff;
        pv = '0;
        sel = '0;
        req = '0;
        tick(2);
        rst <= 1'b0;
        rd(irq_pkg::ADDR_STATUS, 16'h0004);
        rd(irq_pkg::ADDR_ENABLE, 16'h0000);
        rd(irq_pkg::ADDR_CONFIG, 16'h0000);
        accept(irq_pkg::KIND_RESET, 16'hfffc);
        // Deselected sources stay quiet
        pulse(15'h07ff);
        tick(2);
        rd(irq_pkg::ADDR_REQUEST, 16'h2010);
        wr(irq_pkg::ADDR_REQUEST, 16'hffff);
        rd(irq_pkg::ADDR_REQUEST, 16'h0000);
        @(posedge mclk);
        sel <= '1;
        // Each event lands in its own request bit, then clears
        for (int i = 0; i < 11; i++)
        begin
            pulse(15'(1 << i));
            tick(2);
            rd(irq_pkg::ADDR_REQUEST, 16'(1 << (i + 4)));
            wr(irq_pkg::ADDR_REQUEST, 16'(1 << (i + 4)));
            rd(irq_pkg::ADDR_REQUEST, 16'h0000);
        end
        // Flag set and clear instructions
        pulse(15'h2000);
        rd(irq_pkg::ADDR_STATUS, 16'h0000);
        pulse(15'h1000);
        rd(irq_pkg::ADDR_STATUS, 16'h0004);
        // Two pending: higher one wins, the other waits
        pulse(15'h0021);
        wr(irq_pkg::ADDR_ENABLE, 16'h7fff);
        pulse(15'h2000);
        accept(irq_pkg::KIND_MASKABLE, 16'hfff2);
        rd(irq_pkg::ADDR_REQUEST, 16'h0200);
        rd(irq_pkg::ADDR_STATUS, 16'h0004);
        accept(irq_pkg::KIND_NONE, 16'h0000);
        // Software holds slot 9 back by its enable bit
        wr(irq_pkg::ADDR_ENABLE, 16'h7dff);
        pulse(15'h2000);
        accept(irq_pkg::KIND_NONE, 16'h0000);
        wr(irq_pkg::ADDR_ENABLE, 16'h7fff);
        accept(irq_pkg::KIND_MASKABLE, 16'hffe8);
        // Break passes the disable flag
        pulse(15'h0001);
        pulse(15'h0800);
        accept(irq_pkg::KIND_BREAK, 16'hffdc);
        pulse(15'h2000);
        accept(irq_pkg::KIND_MASKABLE, 16'hfff2);
        // Pin edges, key select, counter b select, unmapped place
        wr(irq_pkg::ADDR_CONFIG, 16'h006a);
        rd(irq_pkg::ADDR_CONFIG, 16'h006a);
        wr(3'h5, 16'hffff);
        rd(3'h5, 16'h0000);
        wr(irq_pkg::ADDR_REQUEST, 16'hffff);
        set_pins(5'b11111, 8'hff);
        set_pins(5'b00000, 8'hf7);
        pulse(15'h0200);
        set_pins(5'b00000, 8'hff);
        rd(irq_pkg::ADDR_REQUEST, 16'h200f);
        pulse(15'h2000);
        accept(irq_pkg::KIND_MASKABLE, 16'hfffa);
        rd(irq_pkg::ADDR_REQUEST, 16'h200e);
        // Pin c owns the shared slot, keys and counter b deselected
        wr(irq_pkg::ADDR_CONFIG, 16'h0015);
        wr(irq_pkg::ADDR_REQUEST, 16'hffff);
        set_pins(5'b00000, 8'hf7);
        rd(irq_pkg::ADDR_REQUEST, 16'h0000);
        set_pins(5'b10101, 8'hff);
        rd(irq_pkg::ADDR_REQUEST, 16'h0005);
        report_and_stop();
    end
endmodule : test_fixed_priority_vector_irq
